// file: chan_map_pkg.sv
`default_nettype none
package chan_map_pkg;
  // register offsets
  localparam logic [7:0] ADDR_PORT_SEL = 8'h4c;
  localparam logic [7:0] ADDR_RAW_ID = 8'h71;
  localparam logic [7:0] ADDR_REMAP = 8'h72;
  localparam logic [7:0] ADDR_TOTAL_HI = 8'h73;
  localparam logic [7:0] ADDR_TOTAL_LO = 8'h74;
  localparam logic [7:0] ADDR_WIDTH_HI = 8'h75;
  localparam logic [7:0] ADDR_WIDTH_LO = 8'h76;
  // field layout of the 8-bit raw channel/type register
  localparam int VC_LSB = 6;
  localparam int VC_W = 2;
  localparam int DT_LSB = 0;
  localparam int DT_W = 6;
  localparam int PORT_SEL_W = 2;
  localparam int CNT_W = 16;
  // reset values
  localparam logic [7:0] RST_PORT_SEL = 8'h00;
  localparam logic [7:0] RST_REMAP = 8'he4;
  localparam logic [5:0] RST_RAW_DT = 6'h2c;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [7:0] RD_ZERO = 8'h00;
  // input modes
  typedef logic [1:0] mode_t;
  localparam mode_t MODE_CSI = 2'h0;
  localparam mode_t MODE_RAW12_50 = 2'h1;
  localparam mode_t MODE_RAW12_75 = 2'h2;
  localparam mode_t MODE_RAW10 = 2'h3;
endpackage
`default_nettype wire

// file: frame_evt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface frame_evt_if;
  logic beat;
  logic sof;
  logic eol;
  logic eof;
  modport src (output beat, output sof, output eol, output eof);
  modport mon (input beat, input sof, input eol, input eof);
endinterface
`default_nettype wire

// file: beat_skid_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module beat_skid_buffer #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  if (W < 1) begin : g_chk
    $error("beat_skid_buffer: W must be at least 1");
  end

  logic head_v_q, head_v_d, skid_v_q, skid_v_d, rdy_q, rdy_d;
  logic [W-1:0] head_q, head_d, skid_q, skid_d;

  // the second slot lets in_ready come from a flop and still lose nothing
  always_comb begin
    head_v_d = head_v_q;
    head_d = head_q;
    skid_v_d = skid_v_q;
    skid_d = skid_q;
    if (!head_v_q || out_ready) begin
      if (skid_v_q) begin
        head_d = skid_q;
        head_v_d = 1'b1;
        skid_v_d = 1'b0;
      end else begin
        head_v_d = in_valid && rdy_q;
        if (in_valid && rdy_q) begin
          head_d = in_data;
        end
      end
    end else if (in_valid && rdy_q) begin
      skid_d = in_data;
      skid_v_d = 1'b1;
    end
    rdy_d = !skid_v_d;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      head_v_q <= 1'b0;
      skid_v_q <= 1'b0;
      rdy_q <= 1'b0;
      head_q <= '0;
      skid_q <= '0;
    end else begin
      head_v_q <= head_v_d;
      skid_v_q <= skid_v_d;
      rdy_q <= rdy_d;
      head_q <= head_d;
      skid_q <= skid_d;
    end
  end

  assign in_ready = rdy_q;
  assign out_valid = head_v_q;
  assign out_data = head_q;
endmodule
`default_nettype wire

// file: frame_line_meter.sv
`timescale 1ns/1ps
`default_nettype none
module frame_line_meter (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // accepted beats
  frame_evt_if.mon ev,
  // freeze enables and read strobes
  input wire logic total_irq_en,
  input wire logic width_irq_en,
  input wire logic rd_total_hi,
  input wire logic rd_width_hi,
  // reported values and change pulses
  output logic [chan_map_pkg::CNT_W-1:0] total_q,
  output logic [chan_map_pkg::CNT_W-1:0] width_q,
  output logic total_chg_q,
  output logic width_chg_q
);
  localparam int CW = chan_map_pkg::CNT_W;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_FRAME = 2'b10} meter_st_e;

  meter_st_e st_q, st_d;
  logic [CW-1:0] len_acc_q, len_acc_d, lines_q, lines_d, last_len_q, last_len_d;
  logic [CW-1:0] total_d, width_d, base_len, base_lines, cur_len, cur_lines;
  logic [CW-1:0] cand_total, cand_width;
  logic tot_frz_q, tot_frz_d, wid_frz_q, wid_frz_d, total_chg_d, width_chg_d;
  logic fin, upd_t, upd_w;

  always_comb begin
    st_d = st_q;
    len_acc_d = len_acc_q;
    lines_d = lines_q;
    last_len_d = last_len_q;
    total_d = total_q;
    width_d = width_q;
    base_len = ev.sof ? '0 : len_acc_q;
    base_lines = ev.sof ? '0 : lines_q;
    cur_len = base_len + CW'(1);
    cur_lines = base_lines + CW'(ev.eol);
    cand_total = cur_lines;
    cand_width = ev.eol ? cur_len : last_len_q;
    fin = 1'b0;
    if (ev.beat) begin
      len_acc_d = ev.eol ? '0 : cur_len;
      lines_d = cur_lines;
      if (ev.eol) begin
        last_len_d = cur_len;
      end
      unique case (st_q)
        ST_IDLE: begin
          if (ev.sof) begin
            st_d = ST_FRAME;
          end
        end
        ST_FRAME: begin
          st_d = ST_FRAME;
        end
        default: st_d = ST_IDLE;
      endcase
      if (ev.eof && (st_q == ST_FRAME || ev.sof)) begin
        st_d = ST_IDLE;
        fin = 1'b1;
      end
    end
    // a read releases the freeze in the same cycle a new frame may land
    upd_t = fin && (!tot_frz_q || rd_total_hi);
    upd_w = fin && (!wid_frz_q || rd_width_hi);
    total_chg_d = upd_t && cand_total != total_q;
    width_chg_d = upd_w && cand_width != width_q;
    if (upd_t) begin
      total_d = cand_total;
    end
    if (upd_w) begin
      width_d = cand_width;
    end
    // set wins over the clearing read
    tot_frz_d = (tot_frz_q && !rd_total_hi) || (total_chg_d && total_irq_en);
    wid_frz_d = (wid_frz_q && !rd_width_hi) || (width_chg_d && width_irq_en);
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      len_acc_q <= '0;
      lines_q <= '0;
      last_len_q <= '0;
      total_q <= chan_map_pkg::RST_CNT;
      width_q <= chan_map_pkg::RST_CNT;
      tot_frz_q <= 1'b0;
      wid_frz_q <= 1'b0;
      total_chg_q <= 1'b0;
      width_chg_q <= 1'b0;
    end else begin
      st_q <= st_d;
      len_acc_q <= len_acc_d;
      lines_q <= lines_d;
      last_len_q <= last_len_d;
      total_q <= total_d;
      width_q <= width_d;
      tot_frz_q <= tot_frz_d;
      wid_frz_q <= wid_frz_d;
      total_chg_q <= total_chg_d;
      width_chg_q <= width_chg_d;
    end
  end

  property p_total_at_end;
    @(posedge clk) disable iff (!resetn)
    fin && !tot_frz_q |=> total_q == $past(cand_total);
  endproperty
  a_total_at_end: assert property (p_total_at_end) else $error("line total not taken at frame end");
endmodule
`default_nettype wire

// file: port_channel_map_line_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module port_channel_map_line_monitor #(
  parameter int PORT_ID = 0,
  parameter int DATA_W = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port from the i2c target
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // port configuration
  input wire logic [1:0] link_input_mode,
  input wire logic line_total_change_irq_en,
  input wire logic line_width_change_irq_en,
  // incoming beats
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [1:0] in_vc,
  input wire logic [5:0] in_dt,
  input wire logic [DATA_W-1:0] in_data,
  input wire logic in_sof,
  input wire logic in_eol,
  input wire logic in_eof,
  // outgoing beats
  output logic out_valid,
  input wire logic out_ready,
  output logic [1:0] out_vc,
  output logic [5:0] out_dt,
  output logic [DATA_W-1:0] out_data,
  output logic out_sof,
  output logic out_eol,
  output logic out_eof,
  // change events
  output logic line_total_changed,
  output logic line_width_changed
);
  localparam int VCW = chan_map_pkg::VC_W;
  localparam int DTW = chan_map_pkg::DT_W;
  localparam int BW = VCW + DTW + 3 + DATA_W;
  localparam int CW = chan_map_pkg::CNT_W;

  if (PORT_ID < 0 || PORT_ID >= chan_map_pkg::PORT_SEL_W) begin : g_chk_port
    $error("PORT_ID must be 0 or 1");
  end
  if (DATA_W < 8) begin : g_chk_data
    $error("DATA_W must hold at least one byte");
  end

  localparam logic [VCW-1:0] PORT_VC = VCW'(PORT_ID);

  // register state
  logic [7:0] port_sel_q, port_sel_d, raw_id_q, raw_id_d, remap_q, remap_d;
  logic [7:0] total_hold_q, total_hold_d, width_hold_q, width_hold_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic sel, answer_sel;
  logic rd_total_hi, rd_width_hi;
  logic [CW-1:0] total_val, width_val;
  logic total_chg, width_chg;

  // the select register is copied in every port so all ports agree on it
  assign sel = port_sel_q[PORT_ID];
  assign answer_sel = (PORT_ID == 0);
  assign rd_total_hi = reg_rd && sel && reg_addr == chan_map_pkg::ADDR_TOTAL_HI;
  assign rd_width_hi = reg_rd && sel && reg_addr == chan_map_pkg::ADDR_WIDTH_HI;

  always_comb begin
    port_sel_d = port_sel_q;
    raw_id_d = raw_id_q;
    remap_d = remap_q;
    total_hold_d = total_hold_q;
    width_hold_d = width_hold_q;
    rdata_d = chan_map_pkg::RD_ZERO;
    rvalid_d = 1'b0;
    if (reg_wr) begin
      if (reg_addr == chan_map_pkg::ADDR_PORT_SEL) begin
        port_sel_d = reg_wdata;
      end else if (sel) begin
        unique case (reg_addr)
          chan_map_pkg::ADDR_RAW_ID: raw_id_d = reg_wdata;
          chan_map_pkg::ADDR_REMAP: remap_d = reg_wdata;
          default: ;
        endcase
      end
    end
    if (reg_rd) begin
      if (reg_addr == chan_map_pkg::ADDR_PORT_SEL) begin
        rvalid_d = answer_sel;
        rdata_d = port_sel_q;
      end else if (sel) begin
        // unmapped port offsets still answer, with zero
        rvalid_d = 1'b1;
        unique case (reg_addr)
          chan_map_pkg::ADDR_RAW_ID: rdata_d = raw_id_q;
          chan_map_pkg::ADDR_REMAP: rdata_d = remap_q;
          chan_map_pkg::ADDR_TOTAL_HI: begin
            rdata_d = total_val[CW-1:8];
            total_hold_d = total_val[7:0];
          end
          chan_map_pkg::ADDR_TOTAL_LO: rdata_d = total_hold_q;
          chan_map_pkg::ADDR_WIDTH_HI: begin
            rdata_d = width_val[CW-1:8];
            width_hold_d = width_val[7:0];
          end
          chan_map_pkg::ADDR_WIDTH_LO: rdata_d = width_hold_q;
          default: rdata_d = chan_map_pkg::RD_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      port_sel_q <= chan_map_pkg::RST_PORT_SEL;
      raw_id_q <= {PORT_VC, chan_map_pkg::RST_RAW_DT};
      remap_q <= chan_map_pkg::RST_REMAP;
      total_hold_q <= chan_map_pkg::RD_ZERO;
      width_hold_q <= chan_map_pkg::RD_ZERO;
      rdata_q <= chan_map_pkg::RD_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      port_sel_q <= port_sel_d;
      raw_id_q <= raw_id_d;
      remap_q <= remap_d;
      total_hold_q <= total_hold_d;
      width_hold_q <= width_hold_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  // channel and type mapping, applied before the buffer
  logic [VCW-1:0] map_vc;
  logic [DTW-1:0] map_dt;
  logic is_raw12;
  logic [BW-1:0] buf_in, buf_out;
  logic buf_ready, buf_valid;

  assign is_raw12 = link_input_mode == chan_map_pkg::MODE_RAW12_50 ||
                    link_input_mode == chan_map_pkg::MODE_RAW12_75;

  always_comb begin
    map_vc = in_vc;
    map_dt = in_dt;
    unique case (link_input_mode)
      chan_map_pkg::MODE_CSI: begin
        map_vc = remap_q[{in_vc, 1'b0} +: VCW];
      end
      chan_map_pkg::MODE_RAW12_50, chan_map_pkg::MODE_RAW12_75: begin
        map_vc = raw_id_q[chan_map_pkg::VC_LSB +: VCW];
        map_dt = raw_id_q[chan_map_pkg::DT_LSB +: DTW];
      end
      // raw10 tagging is done upstream; beats pass unchanged
      chan_map_pkg::MODE_RAW10: ;
    endcase
  end

  assign buf_in = {map_vc, map_dt, in_sof, in_eol, in_eof, in_data};

  beat_skid_buffer #(.W(BW)) u_buf (
    .clk(clk),
    .resetn(resetn),
    .in_valid(in_valid),
    .in_ready(buf_ready),
    .in_data(buf_in),
    .out_valid(buf_valid),
    .out_ready(out_ready),
    .out_data(buf_out)
  );

  assign in_ready = buf_ready;
  assign out_valid = buf_valid;
  assign {out_vc, out_dt, out_sof, out_eol, out_eof, out_data} = buf_out;

  // line metering on accepted beats
  frame_evt_if ev ();
  assign ev.beat = in_valid && buf_ready;
  assign ev.sof = in_sof;
  assign ev.eol = in_eol;
  assign ev.eof = in_eof;

  frame_line_meter u_meter (
    .clk(clk),
    .resetn(resetn),
    .ev(ev),
    .total_irq_en(line_total_change_irq_en),
    .width_irq_en(line_width_change_irq_en),
    .rd_total_hi(rd_total_hi),
    .rd_width_hi(rd_width_hi),
    .total_q(total_val),
    .width_q(width_val),
    .total_chg_q(total_chg),
    .width_chg_q(width_chg)
  );

  assign line_total_changed = total_chg;
  assign line_width_changed = width_chg;

  // checks
  logic in_fire;
  assign in_fire = in_valid && buf_ready;

  property p_sel_gate;
    @(posedge clk) disable iff (!resetn)
    reg_wr && !sel && reg_addr == chan_map_pkg::ADDR_REMAP |=> remap_q == $past(remap_q);
  endproperty
  a_sel_gate: assert property (p_sel_gate) else $error("unselected port took a write");

  property p_raw12_map;
    @(posedge clk) disable iff (!resetn)
    in_fire && is_raw12 |-> buf_in[BW-1 -: VCW] == raw_id_q[chan_map_pkg::VC_LSB +: VCW]
      && buf_in[BW-VCW-1 -: DTW] == raw_id_q[chan_map_pkg::DT_LSB +: DTW];
  endproperty
  a_raw12_map: assert property (p_raw12_map) else $error("raw12 tag not applied");

  property p_vc_reset;
    @(posedge clk) !resetn ##1 resetn |-> raw_id_q[chan_map_pkg::VC_LSB +: VCW] == PORT_VC;
  endproperty
  a_vc_reset: assert property (p_vc_reset) else $error("raw12 channel reset wrong");

  property p_dt_reset;
    @(posedge clk) !resetn ##1 resetn |-> raw_id_q[chan_map_pkg::DT_LSB +: DTW] ==
      chan_map_pkg::RST_RAW_DT && remap_q == chan_map_pkg::RST_REMAP;
  endproperty
  a_dt_reset: assert property (p_dt_reset) else $error("type or remap reset wrong");

  property p_csi_dt;
    @(posedge clk) disable iff (!resetn)
    in_fire && link_input_mode == chan_map_pkg::MODE_CSI |-> buf_in[BW-VCW-1 -: DTW] == in_dt;
  endproperty
  a_csi_dt: assert property (p_csi_dt) else $error("csi data type altered");

  property p_remap;
    @(posedge clk) disable iff (!resetn)
    in_fire && link_input_mode == chan_map_pkg::MODE_CSI && in_vc == 2'h3
      |-> buf_in[BW-1 -: VCW] == remap_q[7:6];
  endproperty
  a_remap: assert property (p_remap) else $error("channel 3 remap wrong");

  property p_total_read;
    @(posedge clk) disable iff (!resetn)
    rd_total_hi |=> reg_rvalid && reg_rdata == $past(total_val[15:8]);
  endproperty
  a_total_read: assert property (p_total_read) else $error("upper total read wrong");

  property p_total_freeze;
    @(posedge clk) disable iff (!resetn)
    total_chg && line_total_change_irq_en && !rd_total_hi |=> $stable(total_val);
  endproperty
  a_total_freeze: assert property (p_total_freeze) else $error("frozen total moved");

  property p_total_pair;
    @(posedge clk) disable iff (!resetn)
    // the host leaves an idle cycle between reads; the hold must survive it
    rd_total_hi ##1 !rd_total_hi ##1 (reg_rd && sel && reg_addr == chan_map_pkg::ADDR_TOTAL_LO)
      |=> reg_rdata == $past(total_val[7:0], 3);
  endproperty
  a_total_pair: assert property (p_total_pair) else $error("lower total not coherent");

  property p_width_freeze;
    @(posedge clk) disable iff (!resetn)
    width_chg && line_width_change_irq_en && !rd_width_hi |=> $stable(width_val);
  endproperty
  a_width_freeze: assert property (p_width_freeze) else $error("frozen width moved");

  property p_width_pair;
    @(posedge clk) disable iff (!resetn)
    rd_width_hi |=> reg_rdata == $past(width_val[15:8]) && width_hold_q == $past(width_val[7:0]);
  endproperty
  a_width_pair: assert property (p_width_pair) else $error("width bytes not coherent");

  property p_raw10_pass;
    @(posedge clk) disable iff (!resetn)
    in_fire && link_input_mode == chan_map_pkg::MODE_RAW10 |-> buf_in[BW-1 -: VCW] == in_vc;
  endproperty
  a_raw10_pass: assert property (p_raw10_pass) else $error("raw10 beat altered");

  c_csi_beat: cover property (@(posedge clk) in_fire && link_input_mode == chan_map_pkg::MODE_CSI);
  c_raw12_beat: cover property (@(posedge clk) in_fire && is_raw12);
  c_stall: cover property (@(posedge clk) in_valid && !buf_ready);
  c_total_chg: cover property (@(posedge clk) total_chg ##[1:20] rd_total_hi);
endmodule
`default_nettype wire

// file: reg_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the register port: one strobe per access, one idle cycle after
module reg_host_model (
  // clock
  input wire logic clk,
  // register requests
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  task automatic req(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // released lines show the inverse so a stale value never passes
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // port registers are only reachable once the selection is written
  task automatic select_port(input logic [7:0] mask);
    req(1'b1, chan_map_pkg::ADDR_PORT_SEL, mask);
  endtask
endmodule
`default_nettype wire

// file: port_channel_map_line_monitor_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module port_channel_map_line_monitor_tb_top;
  localparam int PID = 1;
  logic clk, resetn, reg_wr, reg_rd, reg_rvalid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tbl, raw_id;
  logic [1:0] link_input_mode, in_vc, out_vc;
  logic ten, wen, in_valid, in_ready, in_sof, in_eol, in_eof;
  logic out_valid, out_ready, out_sof, out_eol, out_eof, stall, tot_chg, wid_chg;
  logic [5:0] in_dt, out_dt;
  logic [11:0] in_data, out_data;
  logic [22:0] bq[$];
  logic [22:0] out_beat;
  logic [7:0] rq[$];
  int fails, tests_run, n_tot, n_wid, n_refuse;

  port_channel_map_line_monitor #(.PORT_ID(PID), .DATA_W(12)) port_channel_map_line_monitor_i (
    .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .link_input_mode(link_input_mode), .line_total_change_irq_en(ten),
    .line_width_change_irq_en(wen), .in_valid(in_valid), .in_ready(in_ready),
    .in_vc(in_vc), .in_dt(in_dt), .in_data(in_data), .in_sof(in_sof), .in_eol(in_eol),
    .in_eof(in_eof), .out_valid(out_valid), .out_ready(out_ready), .out_vc(out_vc),
    .out_dt(out_dt), .out_data(out_data), .out_sof(out_sof), .out_eol(out_eol),
    .out_eof(out_eof), .line_total_changed(tot_chg), .line_width_changed(wid_chg)
  );

  reg_host_model reg_host_model_i (
    .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_reg(input logic [7:0] e, input logic [7:0] g);
    chk("reg_rdata", {24'h0, e}, {24'h0, g});
  endtask

  task automatic chk_beat(input logic [22:0] e, input logic [22:0] g);
    chk("out beat", {9'h0, e}, {9'h0, g});
  endtask

  assign out_beat = {out_vc, out_dt, out_data, out_sof, out_eol, out_eof};

  // stalls come from the receiver side; a long stall forces the buffer full
  always @(posedge clk) begin
    #1;
    out_ready = !stall && ($urandom % 4 != 0);
  end

  // watcher: every answer takes the oldest note off its queue
  always @(posedge clk) begin
    if (resetn) begin
      if (reg_rvalid) begin
        if (rq.size() == 0) chk("unexpected reg_rvalid", 32'h0, 32'h1);
        else chk_reg(rq.pop_front(), reg_rdata);
      end
      if (out_valid && out_ready) begin
        if (bq.size() == 0) chk("unexpected out beat", 32'h0, 32'h1);
        else chk_beat(bq.pop_front(), out_beat);
      end
      n_tot += int'(tot_chg === 1'b1);
      n_wid += int'(wid_chg === 1'b1);
      n_refuse += int'(in_valid && in_ready === 1'b0);
    end
  end

  function automatic logic [22:0] map_beat(input logic [1:0] vc, input logic [5:0] dt,
    input logic [11:0] d, input logic [2:0] f);
    case (link_input_mode)
      chan_map_pkg::MODE_CSI: map_beat = {tbl[{vc, 1'b0} +: 2], dt, d, f};
      chan_map_pkg::MODE_RAW10: map_beat = {vc, dt, d, f};
      default: map_beat = {raw_id, d, f};
    endcase
  endfunction

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rq.push_back(e);
    reg_host_model_i.req(1'b0, a, 8'h00);
  endtask

  task automatic beat(input logic [1:0] vc, input logic [5:0] dt, input logic [11:0] d,
    input logic [2:0] f);
    int n;
    in_valid = 1'b1;
    in_vc = vc;
    in_dt = dt;
    in_data = d;
    {in_sof, in_eol, in_eof} = f;
    bq.push_back(map_beat(vc, dt, d, f));
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (in_ready !== 1'b1 && n < 100);
    if (in_ready !== 1'b1) begin
      fails++;
      summarize();
    end
    #1;
  endtask

  task automatic drop();
    in_valid = 1'b0;
    in_vc = ~in_vc;
    in_dt = ~in_dt;
    in_data = ~in_data;
    {in_sof, in_eol, in_eof} = ~{in_sof, in_eol, in_eof};
  endtask

  task automatic drain();
    int n;
    n = 0;
    while (bq.size() != 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (bq.size() != 0) begin
      fails++;
      summarize();
    end
    @(posedge clk);
    #1;
  endtask

  // every line one beat long except the last, so the width is the final line's
  task automatic frame(input int lines, input int last);
    int len;
    for (int l = 0; l < lines; l++) begin
      len = (l == lines - 1) ? last : 1;
      for (int b = 0; b < len; b++) begin
        beat(2'($urandom), 6'($urandom), 12'($urandom),
          {l == 0 && b == 0, b == len - 1, l == lines - 1 && b == len - 1});
      end
    end
    drop();
  endtask

  initial begin
    {resetn, in_valid, in_sof, in_eol, in_eof, ten, wen, stall} = 8'h0;
    {in_vc, in_dt, in_data} = 20'h0;
    link_input_mode = chan_map_pkg::MODE_CSI;
    {fails, tests_run, n_tot, n_wid, n_refuse} = '0;
    void'($urandom(17));
    tbl = chan_map_pkg::RST_REMAP;
    raw_id = {2'(PID), chan_map_pkg::RST_RAW_DT};
    repeat (16) @(posedge clk);
    #1;
    resetn = 1'b1;
    // not selected yet: the access must go unanswered
    reg_host_model_i.req(1'b0, chan_map_pkg::ADDR_RAW_ID, 8'h00);
    reg_host_model_i.req(1'b1, chan_map_pkg::ADDR_REMAP, 8'h1b);
    reg_host_model_i.select_port(8'h02);
    rd(chan_map_pkg::ADDR_RAW_ID, raw_id);
    rd(chan_map_pkg::ADDR_REMAP, tbl);
    for (int a = 3; a < 7; a++) begin
      reg_host_model_i.req(1'b1, 8'(8'h70 + a), 8'hff);
      rd(8'(8'h70 + a), 8'h00);
    end
    raw_id = 8'($urandom);
    tbl = 8'($urandom);
    reg_host_model_i.req(1'b1, chan_map_pkg::ADDR_RAW_ID, raw_id);
    reg_host_model_i.req(1'b1, chan_map_pkg::ADDR_REMAP, tbl);
    rd(chan_map_pkg::ADDR_RAW_ID, raw_id);
    rd(chan_map_pkg::ADDR_REMAP, tbl);
    for (int m = 0; m < 4; m++) begin
      drain();
      link_input_mode = 2'(m);
      stall = 1'b1;
      fork
        begin
          repeat (8) @(posedge clk);
          #1;
          stall = 1'b0;
        end
      join_none
      repeat (8) beat(2'($urandom), 6'($urandom), 12'($urandom), 3'h0);
      drop();
    end
    drain();
    link_input_mode = chan_map_pkg::MODE_CSI;
    frame(300, 258);
    rd(chan_map_pkg::ADDR_TOTAL_HI, 8'h01);
    rd(chan_map_pkg::ADDR_WIDTH_HI, 8'h01);
    frame(2, 3);
    rd(chan_map_pkg::ADDR_TOTAL_LO, 8'h2c);
    rd(chan_map_pkg::ADDR_WIDTH_HI, 8'h00);
    rd(chan_map_pkg::ADDR_WIDTH_LO, 8'h03);
    ten = 1'b1;
    wen = 1'b1;
    frame(6, 7);
    frame(5, 4);
    rd(chan_map_pkg::ADDR_TOTAL_HI, 8'h00);
    rd(chan_map_pkg::ADDR_TOTAL_LO, 8'h06);
    rd(chan_map_pkg::ADDR_WIDTH_HI, 8'h00);
    rd(chan_map_pkg::ADDR_WIDTH_LO, 8'h07);
    frame(4, 5);
    rd(chan_map_pkg::ADDR_TOTAL_HI, 8'h00);
    rd(chan_map_pkg::ADDR_TOTAL_LO, 8'h04);
    rd(chan_map_pkg::ADDR_WIDTH_HI, 8'h00);
    rd(chan_map_pkg::ADDR_WIDTH_LO, 8'h05);
    drain();
    repeat (4) @(posedge clk);
    chk("unanswered reads", 32'h0, 32'(rq.size()));
    chk("total change pulses", 32'd4, 32'(n_tot));
    chk("width change pulses", 32'd4, 32'(n_wid));
    chk("refused while full", 32'h1, 32'(n_refuse > 0));
    summarize();
  end
endmodule
`default_nettype wire
